// ---- include/pes_pkg.sv ----
// constants and types for the performance event selector and counter
package pes_pkg;
   // ------------------------------------------------------------
   // event codes and unit masks
   // ------------------------------------------------------------
   localparam logic [7:0] EV_CROSS_SNOOP = 8'h78;
   localparam logic [7:0] EV_HIT_DRV = 8'h7A;
   localparam logic [7:0] EV_SNOOP_HIT_MODIFIED_PIN_DRV = 8'h7B;
   localparam logic [7:0] EV_BUSQ_IDLE = 8'h7D;
   localparam logic [7:0] EV_STALL = 8'h7E;
   localparam logic [7:0] EV_IO_WAIT = 8'h7F;
   localparam logic [7:0] EV_FETCH = 8'h80;
   localparam logic [7:0] EV_FETCH_MISS = 8'h81;
   localparam logic [7:0] EV_ITLB = 8'h82;
   localparam logic [7:0] UM_NONE = 8'h00;
   localparam logic [7:0] UM_SMALL = 8'h02;
   localparam logic [7:0] UM_LARGE = 8'h10;
   localparam logic [7:0] UM_THIS_CORE_ONLY_QUALIFIER = 8'h40;
   localparam logic [7:0] UM_BOTH = 8'hC0;
   // ------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [3:0] REG_SELECT = 4'h0;
   localparam logic [3:0] REG_COUNT = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam int SEL_CODE_LSB = 0;
   localparam int SEL_UMASK_LSB = 8;
   localparam int SEL_EN_BIT = 16;
   localparam int ST_STALL_BIT = 16;
   localparam int ST_BUSY_BIT = 17;
   localparam int ST_DEFER_LSB = 20;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [31:0] ONE32 = 32'h0000_0001;
   // ------------------------------------------------------------
   // snoop timing and line store
   // ------------------------------------------------------------
   localparam int SNOOP_RESP_BUS_CYCLES = 3;
   localparam logic [1:0] SNOOP_LIMIT = 2'(SNOOP_RESP_BUS_CYCLES);
   localparam int LINES = 4;
   localparam int IDX_W = 2;
   typedef enum logic [3:0] {
      LN_INV = 4'h1,
      LN_SHR = 4'h2,
      LN_EXC = 4'h4,
      LN_MOD = 4'h8
   } pes_line_e;
   typedef enum logic [1:0] {
      SN_IDLE = 2'h1,
      SN_WAIT = 2'h2
   } pes_snoop_e;
endpackage

// ---- verilog/pes_counter.sv ----
// performance event selector, counter and cross-core snoop line logic
// Summary of operation
// - code 7AH counts each bus cycle this agent drives hit response.
// - code 7BH counts each bus cycle this agent drives hit-modified.
// - code 7DH counts cycles with no pending bus queue entry.
// - code 7DH also counts cycles halted while other core runs.
// - code 7DH qualifier picks this core alone or both cores.
// - code 7EH counts each snoop stall assertion once, however long it is held.
// - no new snoop-needing transaction starts while snoop stall stands.
// - assert snoop stall when a snoop answer cannot come in three cycles.
// - code 7FH this_core_only_qualifier counts cycles this core has waiting i/o.
// - code 7FH both adds one when either core has waiting i/o.
// - code 80H mask 00H counts every fetch, uncacheable included.
// - code 81H counts fetch unit misses and uncacheable fetches.
// - a fetch unit miss counts once, not per outstanding cycle.
// - code 82H mask 02H counts small page itlb misses.
// - code 82H mask 10H counts large page itlb misses.
// - read snoop hitting exclusive line moves it to shared.
// - ownership snoop hitting exclusive or shared line invalidates it.
// - snoop hitting modified line defers its change to later.
// - cross-core snoops use the data cache store port.
// - code 78H counts data cache snoops for the other core.
`timescale 1ns/100ps
module pes_counter
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [pes_pkg::ADDR_W-1:0] addr,
   input wire logic [pes_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [pes_pkg::DATA_W-1:0] rdata,
   input wire logic hit_drive,
   input wire logic snoop_hit_modified_pin_drive,
   input wire logic busq_pend_this_core_only_qualifier,
   input wire logic busq_pend_other,
   input wire logic halt_this_core_only_qualifier,
   input wire logic halt_other,
   input wire logic io_wait_this_core_only_qualifier,
   input wire logic io_wait_other,
   input wire logic fetch_valid,
   input wire logic fetch_uncache,
   input wire logic fetch_miss,
   input wire logic itlb_miss,
   input wire logic itlb_large,
   input wire logic snoop_stall_pin,
   input wire logic start_req,
   input wire logic start_snoopable,
   output logic bus_start,
   output logic snoop_stall_out,
   input wire logic snoop_req,
   input wire logic [pes_pkg::IDX_W-1:0] snoop_idx,
   input wire logic snoop_rfo,
   output logic snoop_busy,
   output logic snoop_gnt,
   output logic snoop_hit,
   output logic snoop_snoop_hit_modified_pin,
   input wire logic store_req,
   input wire logic [pes_pkg::IDX_W-1:0] store_idx,
   output logic store_gnt,
   input wire logic fill_req,
   input wire logic [pes_pkg::IDX_W-1:0] fill_idx,
   input wire logic fill_excl,
   input wire logic defer_go
);
   import pes_pkg::*;
   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic core_qual(input logic [7:0] um);
      core_qual = (um == UM_THIS_CORE_ONLY_QUALIFIER) || (um == UM_BOTH);
   endfunction
   function automatic logic mask_ok(input logic [7:0] code, input logic [7:0] um);
      case (code)
         EV_HIT_DRV, EV_SNOOP_HIT_MODIFIED_PIN_DRV, EV_FETCH, EV_FETCH_MISS: mask_ok = (um == UM_NONE);
         EV_CROSS_SNOOP, EV_BUSQ_IDLE, EV_STALL, EV_IO_WAIT: mask_ok = core_qual(um);
         EV_ITLB: mask_ok = (um == UM_SMALL) || (um == UM_LARGE);
         default: mask_ok = 1'b0;
      endcase
   endfunction
   logic [7:0] sel_code;
   logic [7:0] sel_umask;
   logic sel_en;
   logic [31:0] cnt;
   logic stall_meta;
   logic stall_sync;
   logic stall_prev;
   logic miss_prev;
   logic next_inc;
   logic serve;
   logic [1:0] wait_cnt;
   logic [IDX_W-1:0] sn_idx;
   logic sn_rfo;
   pes_snoop_e sn_state;
   pes_line_e line [LINES];
   logic [LINES-1:0] defer;
   logic [LINES-1:0] defer_rfo;
   logic [31:0] status;
   logic cnt_wr;
   assign cnt_wr = wr && (addr == REG_COUNT);
   // ------------------------------------------------------------
   // register port
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sel_code <= UM_NONE;
         sel_umask <= UM_NONE;
         sel_en <= 1'b0;
      end
      else if (wr && addr == REG_SELECT)
      begin
         sel_code <= wdata[SEL_CODE_LSB +: 8];
         sel_umask <= wdata[SEL_UMASK_LSB +: 8];
         sel_en <= wdata[SEL_EN_BIT];
      end
   end
   always_ff @(posedge clk)
   begin
      if (!nrst)
         rdata <= ZERO32;
      else if (rd)
      begin
         case (addr)
            REG_SELECT: rdata <= {15'h0000, sel_en, sel_umask, sel_code};
            REG_COUNT: rdata <= cnt;
            REG_STATUS: rdata <= status;
            default: rdata <= ZERO32;
         endcase
      end
      else
         rdata <= ZERO32;
   end
   // ------------------------------------------------------------
   // stall pin synchroniser and edge history
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         stall_meta <= 1'b0;
         stall_sync <= 1'b0;
         stall_prev <= 1'b0;
         miss_prev <= 1'b0;
      end
      else
      begin
         stall_meta <= snoop_stall_pin;
         stall_sync <= stall_meta;
         stall_prev <= stall_sync;
         miss_prev <= fetch_miss;
      end
   end
   // ------------------------------------------------------------
   // event selection
   // ------------------------------------------------------------
   always_comb
   begin
      next_inc = 1'b0;
      if (sel_en && mask_ok(sel_code, sel_umask))
      begin
         case (sel_code)
            EV_HIT_DRV: next_inc = hit_drive;
            EV_SNOOP_HIT_MODIFIED_PIN_DRV: next_inc = snoop_hit_modified_pin_drive;
            EV_BUSQ_IDLE:
            begin
               next_inc = !busq_pend_this_core_only_qualifier || (halt_this_core_only_qualifier && !halt_other);
               if (sel_umask == UM_BOTH)
                  next_inc = next_inc || !busq_pend_other || (halt_other && !halt_this_core_only_qualifier);
            end
            EV_STALL: next_inc = stall_sync && !stall_prev;
            EV_IO_WAIT:
            begin
               // one per cycle even when both cores wait
               if (sel_umask == UM_BOTH)
                  next_inc = io_wait_this_core_only_qualifier || io_wait_other;
               else
                  next_inc = io_wait_this_core_only_qualifier;
            end
            EV_FETCH: next_inc = fetch_valid;
            EV_FETCH_MISS:
               next_inc = (fetch_miss && !miss_prev) || (fetch_valid && fetch_uncache);
            EV_ITLB:
            begin
               if (sel_umask == UM_SMALL)
                  next_inc = itlb_miss && !itlb_large;
               else
                  next_inc = itlb_miss && itlb_large;
            end
            EV_CROSS_SNOOP: next_inc = serve;
            default: next_inc = 1'b0;
         endcase
      end
   end
   // software write wins over a same-cycle increment
   always_ff @(posedge clk)
   begin
      if (!nrst)
         cnt <= ZERO32;
      else if (cnt_wr)
         cnt <= wdata;
      else if (next_inc)
         cnt <= cnt + ONE32;
   end
   // ------------------------------------------------------------
   // bus start gating
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
         bus_start <= 1'b0;
      else
         bus_start <= start_req && !(start_snoopable && (stall_sync || snoop_stall_out));
   end
   // ------------------------------------------------------------
   // snoop sequencing on the store port
   // ------------------------------------------------------------
   // stores keep priority, so a snoop can starve; the stall tells the bus
   assign serve = (sn_state == SN_WAIT) && !store_req;
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sn_state <= SN_IDLE;
         sn_idx <= '0;
         sn_rfo <= 1'b0;
         wait_cnt <= 2'h0;
         snoop_busy <= 1'b0;
      end
      else
      begin
         case (sn_state)
            SN_IDLE:
            begin
               wait_cnt <= 2'h0;
               if (snoop_req)
               begin
                  sn_state <= SN_WAIT;
                  sn_idx <= snoop_idx;
                  sn_rfo <= snoop_rfo;
                  snoop_busy <= 1'b1;
               end
            end
            SN_WAIT:
            begin
               if (serve)
               begin
                  sn_state <= SN_IDLE;
                  snoop_busy <= 1'b0;
               end
               else if (wait_cnt != SNOOP_LIMIT)
                  wait_cnt <= wait_cnt + 2'h1;
            end
            default: sn_state <= SN_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         snoop_stall_out <= 1'b0;
         snoop_gnt <= 1'b0;
         store_gnt <= 1'b0;
         snoop_hit <= 1'b0;
         snoop_snoop_hit_modified_pin <= 1'b0;
      end
      else
      begin
         snoop_stall_out <= (sn_state == SN_WAIT) && !serve
                            && (wait_cnt >= SNOOP_LIMIT - 2'h1);
         snoop_gnt <= serve;
         store_gnt <= store_req;
         snoop_hit <= serve && (line[sn_idx] != LN_INV);
         snoop_snoop_hit_modified_pin <= serve && (line[sn_idx] == LN_MOD);
      end
   end
   // ------------------------------------------------------------
   // line states
   // ------------------------------------------------------------
   generate
      for (genvar i = 0; i < LINES; i++)
      begin : g_line
         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               line[i] <= LN_INV;
               defer[i] <= 1'b0;
               defer_rfo[i] <= 1'b0;
            end
            else if (serve && sn_idx == IDX_W'(i))
            begin
               case (line[i])
                  LN_EXC: line[i] <= sn_rfo ? LN_INV : LN_SHR;
                  LN_SHR: line[i] <= sn_rfo ? LN_INV : LN_SHR;
                  LN_MOD:
                  begin
                     defer[i] <= 1'b1;
                     defer_rfo[i] <= sn_rfo;
                  end
                  default: line[i] <= line[i];
               endcase
            end
            else if (defer[i] && defer_go)
            begin
               line[i] <= defer_rfo[i] ? LN_INV : LN_SHR;
               defer[i] <= 1'b0;
            end
            else if (fill_req && fill_idx == IDX_W'(i))
            begin
               line[i] <= fill_excl ? LN_EXC : LN_SHR;
               defer[i] <= 1'b0;
            end
            else if (store_req && store_idx == IDX_W'(i)
                     && (line[i] == LN_EXC || line[i] == LN_MOD))
               line[i] <= LN_MOD;
         end
         assign status[4*i +: 4] = line[i];
      end
   endgenerate
   assign status[ST_STALL_BIT] = stall_sync;
   assign status[ST_BUSY_BIT] = snoop_busy;
   assign status[ST_DEFER_LSB-1:ST_BUSY_BIT+1] = '0;
   assign status[ST_DEFER_LSB +: LINES] = defer;
   assign status[31:ST_DEFER_LSB+LINES] = '0;
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   stall_late_a: assert property (@(posedge clk) disable iff (!nrst)
      (sn_state == SN_WAIT && store_req) [*3] |=> snoop_stall_out)
      else $error("snoop stall missing after three blocked cycles");
   stall_early_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(snoop_busy) |-> !snoop_stall_out [*3])
      else $error("snoop stall raised too early");
   start_block_a: assert property (@(posedge clk) disable iff (!nrst)
      ((stall_sync || snoop_stall_out) && start_req && start_snoopable) |=> !bus_start)
      else $error("snoopable start during stall");
   cnt_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (!sel_en && !cnt_wr) |=> $stable(cnt))
      else $error("counter moved while disabled");
   hit_count_a: assert property (@(posedge clk) disable iff (!nrst)
      (sel_en && sel_code == EV_HIT_DRV && sel_umask == UM_NONE && hit_drive && !cnt_wr)
      |=> cnt == $past(cnt) + ONE32)
      else $error("hit drive cycle not counted");
   miss_once_a: assert property (@(posedge clk) disable iff (!nrst)
      (sel_code == EV_FETCH_MISS && fetch_miss && miss_prev && !fetch_valid && !cnt_wr)
      |=> $stable(cnt))
      else $error("outstanding miss counted again");
   stall_edge_a: assert property (@(posedge clk) disable iff (!nrst)
      (sel_code == EV_STALL && stall_sync && stall_prev && !cnt_wr) |=> $stable(cnt))
      else $error("held stall counted twice");
   read_shared_a: assert property (@(posedge clk) disable iff (!nrst)
      (serve && !sn_rfo && line[sn_idx] == LN_EXC) |=> line[$past(sn_idx)] == LN_SHR)
      else $error("read snoop left exclusive line");
   rfo_inval_a: assert property (@(posedge clk) disable iff (!nrst)
      (serve && sn_rfo && line[sn_idx] == LN_SHR) |=> line[$past(sn_idx)] == LN_INV)
      else $error("ownership snoop left line valid");
   mod_defer_a: assert property (@(posedge clk) disable iff (!nrst)
      (serve && line[sn_idx] == LN_MOD) |=> line[$past(sn_idx)] == LN_MOD && defer != '0)
      else $error("modified line changed at snoop");
   port_excl_a: assert property (@(posedge clk) disable iff (!nrst)
      !(snoop_gnt && store_gnt))
      else $error("store port granted twice");
endmodule

// ---- dv/pes_src.sv ----
// event source and cross-core snoop model facing the counter block
`timescale 1ns/100ps
module pes_src
   import pes_pkg::*;
(
   input wire logic clk,
   input wire logic snoop_gnt,
   input wire logic snoop_hit,
   input wire logic snoop_snoop_hit_modified_pin,
   input wire logic bus_start,
   output logic [13:0] ev,
   output logic snoop_req,
   output logic [pes_pkg::IDX_W-1:0] snoop_idx,
   output logic snoop_rfo,
   output logic store_req,
   output logic [pes_pkg::IDX_W-1:0] store_idx,
   output logic fill_req,
   output logic [pes_pkg::IDX_W-1:0] fill_idx,
   output logic fill_excl,
   output logic defer_go,
   output logic start_req,
   output logic start_snoopable
);
   // ------------------------------------------------------------
   // idle pattern
   // ------------------------------------------------------------
   // both queues busy at rest so no level event counts between windows
   localparam logic [13:0] BASE = 14'h000c;
   initial
   begin
      ev = BASE;
      {snoop_req, snoop_idx, snoop_rfo, store_req, store_idx} = 7'h00;
      {fill_req, fill_idx, fill_excl, defer_go, start_req, start_snoopable} = 7'h00;
   end
   // ------------------------------------------------------------
   // stimulus tasks
   // ------------------------------------------------------------
   task automatic hold(input logic [13:0] w, input int n);
      @(posedge clk);
      ev <= BASE ^ w;
      repeat (n) @(posedge clk);
      ev <= BASE;
   endtask
   // released qualifiers flip so a stale value is never mistaken for valid
   task automatic snoop(input logic [IDX_W-1:0] i, input logic o, output logic h,
      output logic m, output int k);
      @(posedge clk);
      snoop_req <= 1'h1;
      snoop_idx <= i;
      snoop_rfo <= o;
      @(posedge clk);
      snoop_req <= 1'h0;
      snoop_idx <= ~i;
      snoop_rfo <= ~o;
      k = 0;
      while (snoop_gnt !== 1'h1 && k < 60)
      begin
         @(posedge clk);
         k++;
      end
      h = snoop_hit;
      m = snoop_snoop_hit_modified_pin;
   endtask
   task automatic fill(input logic [IDX_W-1:0] i, input logic e);
      @(posedge clk);
      fill_req <= 1'h1;
      fill_idx <= i;
      fill_excl <= e;
      @(posedge clk);
      fill_req <= 1'h0;
      fill_idx <= ~i;
      fill_excl <= ~e;
   endtask
   task automatic store(input logic [IDX_W-1:0] i, input int n);
      @(posedge clk);
      store_req <= 1'h1;
      store_idx <= i;
      repeat (n) @(posedge clk);
      store_req <= 1'h0;
      store_idx <= ~i;
   endtask
   task automatic defer;
      @(posedge clk);
      defer_go <= 1'h1;
      @(posedge clk);
      defer_go <= 1'h0;
   endtask
   task automatic start(input logic s, output logic b);
      @(posedge clk);
      start_req <= 1'h1;
      start_snoopable <= s;
      @(posedge clk);
      start_req <= 1'h0;
      start_snoopable <= ~s;
      @(posedge clk);
      b = bus_start;
   endtask
endmodule

// ---- dv/tb.sv ----
// this_core_only_qualifier-checking bench for the performance event counter
`timescale 1ns/100ps
module tb;
   import pes_pkg::*;
   localparam int N = 5;
   logic clk, nrst, wr, rd;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [13:0] ev;
   logic [1:0] snoop_idx, store_idx, fill_idx;
   logic snoop_req, snoop_rfo, store_req, fill_req, fill_excl, defer_go, start_req;
   logic start_snoopable, bus_start, snoop_stall_out, snoop_busy, snoop_gnt, snoop_hit;
   logic snoop_snoop_hit_modified_pin, store_gnt;
   int fails = 0;
   int checks = 0;
   // ------------------------------------------------------------
   // instances
   // ------------------------------------------------------------
   pes_counter pes_counter_i (
      .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .hit_drive(ev[0]), .snoop_hit_modified_pin_drive(ev[1]), .busq_pend_this_core_only_qualifier(ev[2]), .busq_pend_other(ev[3]),
      .halt_this_core_only_qualifier(ev[4]), .halt_other(ev[5]), .io_wait_this_core_only_qualifier(ev[6]), .io_wait_other(ev[7]),
      .fetch_valid(ev[8]), .fetch_uncache(ev[9]), .fetch_miss(ev[10]), .itlb_miss(ev[11]),
      .itlb_large(ev[12]), .snoop_stall_pin(ev[13]), .start_req(start_req),
      .start_snoopable(start_snoopable), .bus_start(bus_start),
      .snoop_stall_out(snoop_stall_out), .snoop_req(snoop_req), .snoop_idx(snoop_idx),
      .snoop_rfo(snoop_rfo), .snoop_busy(snoop_busy), .snoop_gnt(snoop_gnt),
      .snoop_hit(snoop_hit), .snoop_snoop_hit_modified_pin(snoop_snoop_hit_modified_pin), .store_req(store_req),
      .store_idx(store_idx), .store_gnt(store_gnt), .fill_req(fill_req),
      .fill_idx(fill_idx), .fill_excl(fill_excl), .defer_go(defer_go)
   );
   pes_src src_i (
      .clk(clk), .snoop_gnt(snoop_gnt), .snoop_hit(snoop_hit), .snoop_snoop_hit_modified_pin(snoop_snoop_hit_modified_pin),
      .bus_start(bus_start), .ev(ev), .snoop_req(snoop_req), .snoop_idx(snoop_idx),
      .snoop_rfo(snoop_rfo), .store_req(store_req), .store_idx(store_idx),
      .fill_req(fill_req), .fill_idx(fill_idx), .fill_excl(fill_excl),
      .defer_go(defer_go), .start_req(start_req), .start_snoopable(start_snoopable)
   );
   initial
   begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp1(input logic g, input logic e);
      cmp32(32'(g), 32'(e));
   endtask
   // read data stand only in the cycle after the strobe: take them mid-cycle
   task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      cmp32(rdata, e);
   endtask
   task automatic run_ev(input logic [7:0] c, input logic [7:0] m, input logic [13:0] w,
      input logic [31:0] e);
      wr_reg(REG_COUNT, ZERO32);
      wr_reg(REG_SELECT, {15'h0000, 1'h1, m, c});
      src_i.hold(w, N);
      repeat (4) @(posedge clk);
      wr_reg(REG_SELECT, {16'h0000, m, c});
      chk_reg(REG_COUNT, e);
   endtask
   task automatic wrap_up;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk_reg(REG_SELECT, ZERO32);
      chk_reg(REG_COUNT, ZERO32);
      chk_reg(REG_STATUS, 32'h0000_1111);
      wr_reg(4'hc, 32'hffff_ffff);
      chk_reg(4'hc, ZERO32);
      wr_reg(REG_COUNT, 32'h1234_5678);
      src_i.hold(14'h0001, N);
      chk_reg(REG_COUNT, 32'h1234_5678);
      $display("test reset done");
   endtask
   task automatic t_events;
      run_ev(EV_HIT_DRV, UM_NONE, 14'h0001, N);
      run_ev(EV_SNOOP_HIT_MODIFIED_PIN_DRV, UM_NONE, 14'h0002, N);
      run_ev(EV_SNOOP_HIT_MODIFIED_PIN_DRV, UM_NONE, 14'h0001, 0);
      run_ev(EV_BUSQ_IDLE, UM_THIS_CORE_ONLY_QUALIFIER, 14'h0004, N);
      run_ev(EV_BUSQ_IDLE, UM_THIS_CORE_ONLY_QUALIFIER, 14'h0010, N);
      run_ev(EV_BUSQ_IDLE, UM_THIS_CORE_ONLY_QUALIFIER, 14'h0008, 0);
      run_ev(EV_BUSQ_IDLE, UM_BOTH, 14'h0008, N);
      run_ev(EV_STALL, UM_THIS_CORE_ONLY_QUALIFIER, 14'h2000, 1);
      run_ev(EV_IO_WAIT, UM_THIS_CORE_ONLY_QUALIFIER, 14'h0080, 0);
      run_ev(EV_IO_WAIT, UM_THIS_CORE_ONLY_QUALIFIER, 14'h0040, N);
      run_ev(EV_IO_WAIT, UM_BOTH, 14'h00c0, N);
      run_ev(EV_FETCH, UM_NONE, 14'h0300, N);
      run_ev(EV_FETCH_MISS, UM_NONE, 14'h0300, N);
      run_ev(EV_FETCH_MISS, UM_NONE, 14'h0100, 0);
      run_ev(EV_FETCH_MISS, UM_NONE, 14'h0400, 1);
      run_ev(EV_ITLB, UM_SMALL, 14'h0800, N);
      run_ev(EV_ITLB, UM_LARGE, 14'h1800, N);
      run_ev(EV_ITLB, UM_LARGE, 14'h0800, 0);
      $display("test events done");
   endtask
   // leaves the snoop count enabled for the blocking scenario
   task automatic t_lines;
      logic h, m;
      int k;
      src_i.fill(2'h0, 1'h1);
      src_i.fill(2'h1, 1'h0);
      src_i.fill(2'h2, 1'h1);
      src_i.fill(2'h3, 1'h1);
      src_i.store(2'h2, 1);
      wr_reg(REG_COUNT, ZERO32);
      wr_reg(REG_SELECT, {15'h0000, 1'h1, UM_THIS_CORE_ONLY_QUALIFIER, EV_CROSS_SNOOP});
      src_i.snoop(2'h0, 1'h0, h, m, k);
      cmp1(h & ~m, 1'h1);
      src_i.snoop(2'h1, 1'h1, h, m, k);
      cmp1(h & ~m, 1'h1);
      src_i.snoop(2'h2, 1'h0, h, m, k);
      cmp1(m, 1'h1);
      chk_reg(REG_STATUS, 32'h0040_4812);
      src_i.defer();
      chk_reg(REG_STATUS, 32'h0000_4212);
      $display("test lines done");
   endtask
   task automatic t_block;
      logic h, m, b;
      int k;
      fork
         src_i.store(2'h1, 14);
         src_i.snoop(2'h3, 1'h1, h, m, k);
         begin
            repeat (7) @(posedge clk);
            cmp1(snoop_stall_out, 1'h1);
            cmp1(snoop_busy, 1'h1);
            cmp1(store_gnt, 1'h1);
            src_i.start(1'h1, b);
            cmp1(b, 1'h0);
            src_i.start(1'h0, b);
            cmp1(b, 1'h1);
         end
      join
      cmp1(k > 13, 1'h1);
      cmp1(h & ~m, 1'h1);
      chk_reg(REG_STATUS, 32'h0000_1212);
      chk_reg(REG_COUNT, 32'h0000_0004);
      cmp1(snoop_stall_out, 1'h0);
      $display("test block done");
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      nrst = 1'h0;
      wr = 1'h0;
      rd = 1'h0;
      addr = 4'h0;
      wdata = ZERO32;
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      t_reset();
      t_events();
      t_lines();
      t_block();
      wrap_up();
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      fails++;
      wrap_up();
   end
endmodule
